/* File: verilog/hcs_pkg.sv */
/*
 Shared constants and types for the hub configuration loader: register
 offsets, reset values, field masks, strap coding, timing and carriers.
 Assumes a 10 MHz system clock.
*/
`default_nettype none

package hcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus identity and strap coding
    // Slave address value is arbitrary; any non-zero address keeps the
    // general call address unanswered
    localparam logic [6:0] SLAVE_ADDR     = 7'h2c;
    localparam logic [1:0] SEL_SMBUS      = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_PORT_DIS  = 8'h0a;
    localparam logic [7:0] ADDR_MAXP_SP   = 8'h0b;
    localparam logic [7:0] ADDR_MAXP_BP   = 8'h0c;
    localparam logic [7:0] ADDR_HCCUR_SP  = 8'h0d;
    localparam logic [7:0] ADDR_HCCUR_BP  = 8'h0e;
    localparam logic [7:0] ADDR_PWR_ON    = 8'h0f;

    ////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam logic [7:0] PORT_DIS_MASK  = 8'h0e;
    localparam int         STAT_DONE_BIT  = 0;
    localparam int         STAT_RESET_BIT = 2;
    localparam logic [7:0] RST_PORT_DIS   = 8'h00;
    localparam logic [7:0] RST_MAXP       = 8'h00;
    localparam logic [7:0] RST_HCCUR      = 8'h32;
    localparam logic [7:0] RST_PWR_ON     = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int PWR_UNIT_MS     = 2;
    localparam int PWR_UNIT_CYCLES = CLK_HZ / 1000 * PWR_UNIT_MS;
    localparam int PWR_CNT_W       = 16;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [7:0] bus_powered_port_disable;
        logic [7:0] self_powered_max_power;
        logic [7:0] bus_powered_max_power;
        logic [7:0] self_powered_controller_current;
        logic [7:0] bus_powered_controller_current;
        logic [7:0] port_power_good_delay;
    } hcs_image_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_WEND,
        ST_RADDR,
        ST_RDATA,
        ST_WAITSTOP
    } hcs_state_e;

endpackage

`default_nettype wire

/* File: verilog/hcs_sync.sv */
/*
 Two-stage synchroniser for a group of pin inputs.
 Assumes inputs are asynchronous to i_mclk; first stage feeds only the second.
*/
`timescale 1ns/1ns
`default_nettype none

module hcs_sync #(
    parameter int                 WIDTH = 1,
    parameter logic [WIDTH-1:0]   INIT  = '0
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            meta_q <= INIT;
            o_q    <= INIT;
        end
        else
        begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/hcs_smbus_config.sv */
/*
 Hub configuration image bytes with the slave-only SMBus loader and the
 port power-good delay timer.
 Assumes SCL and SDA are open-drain wires resolved outside, the straps are
 static pins, and i_port_power_on is a one-cycle pulse on i_mclk.
*/
//
// Behaviour
// [R01] Bus-powered port disable keeps only bits 3..1 (ports 3..1), bit 0 zero.
// [R02] Self-powered max power is held as a count of 2 mA steps.
// [R03] Bus-powered max power is held as a count of 2 mA steps.
// [R04] Self-powered controller current counts 2 mA steps, resets to 50.
// [R05] Bus-powered controller current counts 2 mA steps, resets to 50.
// [R06] Power good follows port power-on after the delay byte times 2 ms.
// [R07] With the straps on SMBus the pins act as slave only, no EEPROM read.
// [R08] In SMBus mode attach waits, without limit, for the load to finish.
// [R09] The block never drives the clock and never starts a transfer.
// [R10] Only Write Byte and Read Byte are answered; others get no answer. Here other write frames are acked up to their third byte.
// [R11] Each access is 7-bit address, 8-bit register index, 8-bit data.
// [R12] The host sends address, register index, then data or a read.
// [R13] A register changes only after a complete valid write protocol.
// [R14] Bytes move most significant bit first in both directions.
// [R15] A START straight followed by STOP returns the slave to idle.
// [R16] Reserved bits read as zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none

module hcs_smbus_config #(
    parameter int POWER_UNIT_CYCLES = hcs_pkg::PWR_UNIT_CYCLES
) (
    input  wire logic               i_mclk,
    input  wire logic               i_reset,
    input  wire logic               i_scl,
    input  wire logic               i_sda,
    input  wire logic               i_config_select_strap_high,
    input  wire logic               i_config_select_strap_low,
    input  wire logic               i_port_power_on,
    output logic                    o_sda,
    output logic                    o_sda_oe,
    output logic                    o_smbus_mode,
    output logic                    o_eeprom_load_enable,
    output logic                    o_usb_attach,
    output logic                    o_port_power_good,
    output hcs_pkg::hcs_image_s     o_config
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus conditions
    logic [1:0] bus_s;
    logic [1:0] strap_s;
    logic       scl_p_q;
    logic       sda_p_q;

    hcs_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_d     ({i_scl, i_sda}),
        .o_q     (bus_s)
    );

    hcs_sync #(.WIDTH(2), .INIT(2'h0)) u_strap_sync (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_d     ({i_config_select_strap_high, i_config_select_strap_low}),
        .o_q     (strap_s)
    );

    wire scl       = bus_s[1];
    wire sda       = bus_s[0];
    wire scl_rise  = scl & ~scl_p_q;
    wire scl_fall  = ~scl & scl_p_q;
    wire start_det = scl & scl_p_q & sda_p_q & ~sda;
    wire stop_det  = scl & scl_p_q & ~sda_p_q & sda;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap capture once after reset release
    // Capture waits two edges so the synchroniser no longer shows its
    // reset value; otherwise the straps would always read as 2'b00
    logic       strap_done_q;
    logic       smbus_q;
    logic [1:0] strap_wait_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            strap_done_q <= 1'b0;
            smbus_q      <= 1'b0;
            strap_wait_q <= 2'h0;
        end
        else if (!strap_done_q)
        begin
            if (strap_wait_q == 2'h2)
            begin
                strap_done_q <= 1'b1;
                smbus_q      <= (strap_s == hcs_pkg::SEL_SMBUS); // [R07]
            end
            else
                strap_wait_q <= strap_wait_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration image and read mux
    hcs_pkg::hcs_image_s cfg_q;
    logic                load_done_q;
    logic [7:0]          reg_q;
    logic [7:0]          sh_q;
    logic                commit;

    wire [7:0] rdata =
        (reg_q == hcs_pkg::ADDR_STATUS)   ? {7'h00, load_done_q} :
        (reg_q == hcs_pkg::ADDR_PORT_DIS) ? cfg_q.bus_powered_port_disable :
        (reg_q == hcs_pkg::ADDR_MAXP_SP)  ? cfg_q.self_powered_max_power :
        (reg_q == hcs_pkg::ADDR_MAXP_BP)  ? cfg_q.bus_powered_max_power :
        (reg_q == hcs_pkg::ADDR_HCCUR_SP) ?
            cfg_q.self_powered_controller_current :
        (reg_q == hcs_pkg::ADDR_HCCUR_BP) ?
            cfg_q.bus_powered_controller_current :
        (reg_q == hcs_pkg::ADDR_PWR_ON)   ? cfg_q.port_power_good_delay :
        8'h00; // [R16]

    wire wr_status = commit & (reg_q == hcs_pkg::ADDR_STATUS);
    wire soft_rst  = wr_status & sh_q[hcs_pkg::STAT_RESET_BIT];

    always_ff @(posedge i_mclk)
    begin
        if (i_reset || soft_rst)
        begin
            cfg_q.bus_powered_port_disable        <= hcs_pkg::RST_PORT_DIS;
            cfg_q.self_powered_max_power          <= hcs_pkg::RST_MAXP;
            cfg_q.bus_powered_max_power           <= hcs_pkg::RST_MAXP;
            cfg_q.self_powered_controller_current <= hcs_pkg::RST_HCCUR; // [R04]
            cfg_q.bus_powered_controller_current  <= hcs_pkg::RST_HCCUR; // [R05]
            cfg_q.port_power_good_delay           <= hcs_pkg::RST_PWR_ON;
            load_done_q                           <= 1'b0;
        end
        else if (commit) // [R13]
        begin
            if (reg_q == hcs_pkg::ADDR_STATUS &&
                sh_q[hcs_pkg::STAT_DONE_BIT])
                load_done_q <= 1'b1;
            if (reg_q == hcs_pkg::ADDR_PORT_DIS)
                cfg_q.bus_powered_port_disable <=
                    sh_q & hcs_pkg::PORT_DIS_MASK; // [R01] [R16]
            if (reg_q == hcs_pkg::ADDR_MAXP_SP)
                cfg_q.self_powered_max_power <= sh_q; // [R02]
            if (reg_q == hcs_pkg::ADDR_MAXP_BP)
                cfg_q.bus_powered_max_power <= sh_q; // [R03]
            if (reg_q == hcs_pkg::ADDR_HCCUR_SP)
                cfg_q.self_powered_controller_current <= sh_q; // [R04]
            if (reg_q == hcs_pkg::ADDR_HCCUR_BP)
                cfg_q.bus_powered_controller_current <= sh_q; // [R05]
            if (reg_q == hcs_pkg::ADDR_PWR_ON)
                cfg_q.port_power_good_delay <= sh_q; // [R06]
        end
    end

    assign o_config = cfg_q;

    ////////////////////////////////////////////////////////////////////////
    // SMBus slave byte engine
    // Only SDA is ever driven; SCL is never held, so no stretching. [R09]
    hcs_pkg::hcs_state_e st_q, st_d;
    logic [3:0]          cnt_q, cnt_d;
    logic                ack_q, ack_d;
    logic                oe_q, oe_d;
    logic [7:0]          sh_d;
    logic [7:0]          reg_d;
    logic                accept;

    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        ack_d  = ack_q;
        oe_d   = oe_q;
        sh_d   = sh_q;
        reg_d  = reg_q;
        commit = 1'b0;
        accept = 1'b0;
        if (!smbus_q)
        begin
            st_d = hcs_pkg::ST_IDLE; // [R07]
            oe_d = 1'b0;
        end
        else if (start_det)
        begin
            oe_d  = 1'b0;
            ack_d = 1'b0;
            cnt_d = 4'h0;
            // Repeated start after the index byte opens a read; the SCL
            // rise ahead of it has already counted one bit [R12]
            if (st_q == hcs_pkg::ST_WDATA && cnt_q == 4'h1)
                st_d = hcs_pkg::ST_RADDR;
            else
                st_d = hcs_pkg::ST_ADDR;
        end
        else if (stop_det)
        begin
            oe_d   = 1'b0;
            ack_d  = 1'b0;
            st_d   = hcs_pkg::ST_IDLE; // [R15]
            commit = (st_q == hcs_pkg::ST_WEND); // [R13]
        end
        else if (st_q == hcs_pkg::ST_IDLE || st_q == hcs_pkg::ST_WAITSTOP)
        begin
            oe_d = 1'b0;
        end
        else if (scl_rise)
        begin
            // A rise in WEND may be the STOP's own clock edge
            if (st_q != hcs_pkg::ST_WEND && !ack_q &&
                cnt_q != hcs_pkg::BITS_PER_BYTE)
            begin
                cnt_d = cnt_q + 4'h1;
                if (st_q != hcs_pkg::ST_RDATA)
                    sh_d = {sh_q[6:0], sda}; // [R14]
            end
        end
        else if (scl_fall)
        begin
            // A fall in WEND means a surplus byte: the write is void
            if (st_q == hcs_pkg::ST_WEND)
                st_d = hcs_pkg::ST_WAITSTOP; // [R10] [R13]
            else if (ack_q)
            begin
                ack_d = 1'b0;
                cnt_d = 4'h0;
                oe_d  = 1'b0;
                case (st_q)
                    hcs_pkg::ST_ADDR:  st_d = hcs_pkg::ST_REG;
                    hcs_pkg::ST_REG:   st_d = hcs_pkg::ST_WDATA;
                    hcs_pkg::ST_WDATA: st_d = hcs_pkg::ST_WEND;
                    hcs_pkg::ST_RADDR:
                    begin
                        st_d = hcs_pkg::ST_RDATA;
                        sh_d = rdata;
                        oe_d = ~rdata[7]; // [R14]
                    end
                    default:           st_d = hcs_pkg::ST_WAITSTOP;
                endcase
            end
            else if (cnt_q == hcs_pkg::BITS_PER_BYTE)
            begin
                ack_d = 1'b1;
                case (st_q)
                    hcs_pkg::ST_ADDR:
                        accept = (sh_q == {hcs_pkg::SLAVE_ADDR, 1'b0}); // [R11]
                    hcs_pkg::ST_REG:
                    begin
                        accept = 1'b1;
                        reg_d  = sh_q; // [R11]
                    end
                    hcs_pkg::ST_WDATA: accept = 1'b1;
                    hcs_pkg::ST_RADDR:
                        accept = (sh_q == {hcs_pkg::SLAVE_ADDR, 1'b1}); // [R10]
                    default:           accept = 1'b0;
                endcase
                oe_d = accept;
                // Wrong address or direction: stay silent until the next STOP or START [R10]
                if (!accept && st_q != hcs_pkg::ST_RDATA)
                begin
                    ack_d = 1'b0;
                    st_d  = hcs_pkg::ST_WAITSTOP;
                end
            end
            else if (st_q == hcs_pkg::ST_RDATA)
            begin
                sh_d = {sh_q[6:0], 1'b0};
                oe_d = ~sh_q[6]; // [R14]
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset || soft_rst)
        begin
            st_q  <= hcs_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            oe_q  <= 1'b0;
            sh_q  <= 8'h00;
            reg_q <= 8'h00;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            ack_q <= ack_d;
            oe_q  <= oe_d;
            sh_q  <= sh_d;
            reg_q <= reg_d;
        end
    end

    assign o_sda_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Port power-good timer, counted in 2 ms units
    logic [hcs_pkg::PWR_CNT_W-1:0] unit_cnt_q;
    logic [7:0]                    units_left_q;
    logic                          pwr_busy_q;

    wire unit_end = (unit_cnt_q ==
                     hcs_pkg::PWR_CNT_W'(POWER_UNIT_CYCLES - 1));

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            unit_cnt_q        <= '0;
            units_left_q      <= 8'h00;
            pwr_busy_q        <= 1'b0;
            o_port_power_good <= 1'b0;
        end
        else if (i_port_power_on)
        begin
            unit_cnt_q        <= '0;
            units_left_q      <= cfg_q.port_power_good_delay; // [R06]
            pwr_busy_q        <= 1'b1;
            o_port_power_good <= 1'b0;
        end
        else if (pwr_busy_q)
        begin
            if (units_left_q == 8'h00)
            begin
                pwr_busy_q        <= 1'b0;
                o_port_power_good <= 1'b1; // [R06]
            end
            else if (unit_end)
            begin
                unit_cnt_q   <= '0;
                units_left_q <= units_left_q - 8'h01;
            end
            else
                unit_cnt_q <= unit_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and attach outputs
    // Attach has no timeout in SMBus mode; a host that never loads keeps
    // the hub off the bus for good.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_sda                <= 1'b0;
            o_smbus_mode         <= 1'b0;
            o_eeprom_load_enable <= 1'b0;
            o_usb_attach         <= 1'b0;
        end
        else
        begin
            o_sda                <= 1'b0;
            o_smbus_mode         <= smbus_q;
            o_eeprom_load_enable <= strap_done_q & ~smbus_q; // [R07]
            o_usb_attach         <= strap_done_q &
                                    (~smbus_q | load_done_q); // [R08]
        end
    end

endmodule

`default_nettype wire

/* File: tb/hcs_smbus_config_asserts.sv */
/*
 Port-level assertions for the hub configuration loader.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

module hcs_smbus_config_asserts #(
    parameter int POWER_UNIT_CYCLES = hcs_pkg::PWR_UNIT_CYCLES
) (
    input wire logic                i_mclk,
    input wire logic                i_reset,
    input wire logic                i_scl,
    input wire logic                i_sda,
    input wire logic                i_port_power_on,
    input wire logic                o_sda,
    input wire logic                o_sda_oe,
    input wire logic                o_smbus_mode,
    input wire logic                o_eeprom_load_enable,
    input wire logic                o_usb_attach,
    input wire logic                o_port_power_good,
    input wire hcs_pkg::hcs_image_s o_config
);
    logic [31:0] pg_cnt_q;
    logic [31:0] pg_cnt_d;
    logic [31:0] pg_exp_q;
    logic [31:0] pg_exp_d;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////////////
    // Edges since the last power-on pulse; zero until the first one.
    // 32 bits is ample here, a far longer run would wrap
    assign pg_cnt_d = i_port_power_on ? 32'h1
                    : pg_cnt_q + 32'(pg_cnt_q != 32'h0);
    assign pg_exp_d = i_port_power_on
                    ? 32'(o_config.port_power_good_delay)
                      * 32'(POWER_UNIT_CYCLES) + 32'h2
                    : pg_exp_q;

    always_ff @(posedge i_mclk)
    begin
        pg_cnt_q <= i_reset ? 32'h0 : pg_cnt_d;
        pg_exp_q <= i_reset ? 32'h0 : pg_exp_d;
    end

    ////////////////////////////////////////////////////////////////////////
    reset_default_a: assert property (
        $fell(i_reset) |-> o_config == 48'h0000_0032_3200 && !o_usb_attach)
        else $error("Config not at defaults after reset");
    port_mask_a: assert property (
        (o_config.bus_powered_port_disable & 8'hf1) == 8'h00)
        else $error("Reserved port disable bit set");
    commit_at_stop_a: assert property (
        !$stable(o_config) |-> i_scl && i_sda)
        else $error("Config changed outside a finished write");
    slave_only_a: assert property (
        o_sda_oe |-> !o_sda && o_smbus_mode)
        else $error("Data line driven high or outside bus mode");
    silent_off_mode_a: assert property (
        !o_smbus_mode |-> !o_sda_oe)
        else $error("Answer while not in bus mode");
    mode_exclusive_a: assert property (
        o_eeprom_load_enable |-> !o_smbus_mode)
        else $error("Memory load and bus mode together");
    attach_after_load_a: assert property (
        o_smbus_mode && $rose(o_usb_attach) |-> i_scl && i_sda)
        else $error("Attach before load finished");
    sda_change_low_a: assert property (
        !$stable(o_sda_oe) |-> !i_scl)
        else $error("Data changed while clock high");
    pg_delay_a: assert property (
        $rose(o_port_power_good) |-> pg_cnt_q == pg_exp_q)
        else $error("Power good at wrong edge");
    pg_clear_a: assert property (
        i_port_power_on |=> !o_port_power_good)
        else $error("Power good not cleared by power on");

    cover property ($rose(o_sda_oe));
    cover property (!$stable(o_config));
    cover property ($rose(o_usb_attach));
    cover property ($rose(o_port_power_good));

endmodule

bind hcs_smbus_config hcs_smbus_config_asserts #(
    .POWER_UNIT_CYCLES(POWER_UNIT_CYCLES)
) u_hcs_smbus_config_asserts (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_port_power_on(i_port_power_on),
    .o_sda(o_sda),
    .o_sda_oe(o_sda_oe),
    .o_smbus_mode(o_smbus_mode),
    .o_eeprom_load_enable(o_eeprom_load_enable),
    .o_usb_attach(o_usb_attach),
    .o_port_power_good(o_port_power_good),
    .o_config(o_config)
);

`default_nettype wire

/* File: tb/hcs_smbus_host.sv */
/*
 SMBus host master model: start, stop and byte transfers.
 Assumes the bench resolves SDA with a pull-up; SCL is driven only here.
*/
`timescale 1ns/1ns
`default_nettype none

module hcs_smbus_host (
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda_oe
);
    // SCL stands high and SDA is released between frames
    initial
    begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Quarters of the 800 ns SCL period, moved at falling mclk edges
    task automatic q(input int n);
        repeat (2 * n) @(negedge i_mclk);
    endtask

    // SDA set mid-low, 50 ns before the slave lets go of its previous bit
    task automatic bit_x(input logic v, output logic s);
        q(1);
        o_sda_oe = ~v;
        q(1);
        o_scl = 1'b1;
        q(1);
        s = i_sda;
        q(1);
        o_scl = 1'b0;
    endtask

    task automatic cond(input logic a, input logic b);
        q(1);
        o_sda_oe = a;
        q(1);
        o_scl = 1'b1;
        q(2);
        o_sda_oe = b;
    endtask

    task automatic start;
        cond(1'b0, 1'b1);
        q(2);
        o_scl = 1'b0;
    endtask

    // Long bus-free time so a commit lands before the next frame
    task automatic stop;
        cond(1'b1, 1'b0);
        q(4);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(nack, s);
    endtask

endmodule

`default_nettype wire

/* File: tb/test_hcs_smbus_config.sv */
/*
 Self-checking bench for the hub configuration loader.
 Assumes the host model is the only master; SDA has a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module test_hcs_smbus_config;
    // Short power unit keeps the power-good waits brief
    localparam int          UNIT = 5;
    localparam logic [7:0]  AW   = {hcs_pkg::SLAVE_ADDR, 1'b0};
    localparam logic [7:0]  AR   = {hcs_pkg::SLAVE_ADDR, 1'b1};
    localparam logic [47:0] DEF  = 48'h0000_0032_3200;
    localparam logic [47:0] IMG  = 48'h0e96_3c81_7e03;

    logic                mclk = 1'b0;
    logic                rst = 1'b1;
    logic [1:0]          strap = hcs_pkg::SEL_SMBUS;
    logic                pwr_on = 1'b0;
    logic                scl;
    logic                sda;
    logic                host_oe;
    logic                dut_sda;
    logic                dut_oe;
    logic                mode;
    logic                eep_en;
    logic                attach;
    logic                pg;
    hcs_pkg::hcs_image_s cfg;
    logic [3:0]          a;
    logic [3:0]          b;
    logic [7:0]          wv [6] = '{8'hff, 8'h96, 8'h3c, 8'h81, 8'h7e, 8'h03};
    int                  num_errors = 0;
    int                  comparisons = 0;

    always #50 mclk = ~mclk;
    // Open-drain wire: low while either party pulls
    assign sda = ~(host_oe | (dut_oe & ~dut_sda));

    hcs_smbus_config #(
        .POWER_UNIT_CYCLES(UNIT)
    ) u_hcs_smbus_config (
        .i_mclk(mclk),
        .i_reset(rst),
        .i_scl(scl),
        .i_sda(sda),
        .i_config_select_strap_high(strap[1]),
        .i_config_select_strap_low(strap[0]),
        .i_port_power_on(pwr_on),
        .o_sda(dut_sda),
        .o_sda_oe(dut_oe),
        .o_smbus_mode(mode),
        .o_eeprom_load_enable(eep_en),
        .o_usb_attach(attach),
        .o_port_power_good(pg),
        .o_config(cfg)
    );

    hcs_smbus_host u_hcs_smbus_host (
        .i_mclk(mclk),
        .i_sda(sda),
        .o_scl(scl),
        .o_sda_oe(host_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // START, then n bytes from the top of v; a[3] is the first ack
    task automatic burst(input int n, input logic [31:0] v);
        logic k;
        u_hcs_smbus_host.start();
        for (int i = 0; i < n; i++)
        begin
            u_hcs_smbus_host.send_byte(v[31-8*i -: 8], k);
            a[3-i] = k;
        end
    endtask

    task automatic probe(input logic [7:0] x);
        burst(1, {x, 24'h000000});
        u_hcs_smbus_host.stop();
        chk(48'(a[3]), 48'h0);
    endtask

    task automatic wr_reg(input logic [7:0] r, input logic [7:0] d);
        burst(3, {AW, r, d, 8'h00});
        u_hcs_smbus_host.stop();
        chk(48'(a[3:1]), 48'h7);
    endtask

    task automatic rd_reg(input logic [7:0] r, input logic [7:0] exp);
        logic [7:0] d;
        burst(2, {AW, r, 16'h0000});
        b = a;
        burst(1, {AR, 24'h000000});
        u_hcs_smbus_host.recv_byte(1'b1, d);
        u_hcs_smbus_host.stop();
        chk(48'({b[3:2], a[3], d}), {37'h0, 3'h7, exp});
    endtask

    // Edges from the power-on pulse until power good is seen
    task automatic pg_time(input int n);
        int j;
        pwr_on = 1'b1;
        @(negedge mclk);
        pwr_on = 1'b0;
        j = 1;
        while (pg !== 1'b1 && j < 100)
        begin
            @(negedge mclk);
            j++;
        end
        chk(48'(j), 48'(n));
        if (j == 100)
            report_and_stop();
    endtask

    task automatic do_reset(input logic [1:0] sel);
        strap = sel;
        rst = 1'b1;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (16) @(negedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(hcs_pkg::SEL_SMBUS);
        chk(cfg, DEF);
        chk(48'({mode, eep_en, attach}), 48'h4);
        rd_reg(hcs_pkg::ADDR_HCCUR_SP, 8'h32);
        rd_reg(hcs_pkg::ADDR_HCCUR_BP, 8'h32);
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(8'h0a + 8'(i), wv[i]);
            rd_reg(8'h0a + 8'(i), i == 0 ? 8'h0e : wv[i]);
        end
        chk(cfg, IMG);
        probe(8'h5a);
        probe(8'h00);
        probe(AR);
        // A surplus data byte voids the whole write
        burst(4, {AW, hcs_pkg::ADDR_MAXP_SP, 8'h11, 8'h22});
        u_hcs_smbus_host.stop();
        chk(48'(a), 48'he);
        burst(2, {AW, hcs_pkg::ADDR_MAXP_BP, 16'h0000});
        u_hcs_smbus_host.start();
        u_hcs_smbus_host.stop();
        rd_reg(hcs_pkg::ADDR_MAXP_BP, 8'h3c);
        chk(cfg, IMG);
        chk(48'(attach), 48'h0);
        wr_reg(hcs_pkg::ADDR_STATUS, 8'h01);
        chk(48'(attach), 48'h1);
        pg_time(3 * UNIT + 2);
        wr_reg(hcs_pkg::ADDR_PWR_ON, 8'h00);
        pg_time(2);
        wr_reg(hcs_pkg::ADDR_STATUS, 8'h04);
        chk(cfg, DEF);
        do_reset(2'b00);
        chk(48'({mode, eep_en, attach}), 48'h3);
        probe(AW);
        report_and_stop();
    end

endmodule

`default_nettype wire
